/* hw/hcr_cfg.svh */
`ifndef HCR_CFG_SVH
`define HCR_CFG_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define HCR_REG_DISP1    16'h0038
`define HCR_REG_DISP2    16'h0039
`define HCR_REG_SELECT   16'h0043
`define HCR_REG_RUNCMD   16'h0045
// ----------------------------------------------------------------
// command word bits and selector codes
// ----------------------------------------------------------------
`define HCR_OP_RUN       0
`define HCR_OP_MODE      1
`define HCR_OP_ARST      2
`define HCR_SEL_TEMP     4'h1
`define HCR_SEL_COND     4'h2
`define HCR_SEL_PRESS    4'h3
// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define HCR_FC_READ      8'h04
`define HCR_FC_WRITE     8'h10
`define HCR_BYTE_COUNT   8'h02
`define HCR_QTY_ONE      16'h0001
`define HCR_REQ_LEN      4'h6
`define HCR_RD_RSP_LEN   4'h5
`define HCR_LRC_LEN      4'h1
`define HCR_CRC_LEN      4'h2
`define HCR_CRC_INIT     16'hFFFF
`define HCR_CRC_POLY     16'hA001
`define HCR_CH_COLON     8'h3A
`define HCR_CH_CR        8'h0D
`define HCR_CH_LF        8'h0A
`define HCR_CH_0         8'h30
`define HCR_CH_9         8'h39
`define HCR_CH_UA        8'h41
`define HCR_CH_UF        8'h46
`define HCR_CH_ALPHA     8'h37
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HCR_CLK_HZ       40000000
`define HCR_TICKS_PER_S  1000
`define HCR_MONITOR_S    180
`define HCR_RSP_TIMEOUT  4000
`endif

/* hw/hcr_pkg.sv */
package hcr_pkg;
`include "hcr_cfg.svh"

  typedef enum logic [2:0] {
    TX_HEAD, TX_BODY, TX_CS0, TX_CS1, TX_CR, TX_LF
  } hcr_tx_ph_t;

  typedef struct packed {
    logic            busy;
    hcr_tx_ph_t      ph;
    logic [3:0]      idx;
    logic [3:0]      len;
    logic [15:0]     cs;
    logic            nib;
    logic [7:0][7:0] bytes_;
    logic [7:0]      data;
    logic            valid;
    logic            last;
  } hcr_tx_t;

  typedef struct packed {
    logic [7:0][7:0] bytes_;
    logic [3:0]      cnt;
    logic [15:0]     cs;
    logic [3:0]      hi;
    logic            nib;
    logic            open;
    logic            done;
    logic            ok;
  } hcr_rx_t;

  typedef struct packed {
    hcr_tx_t     tx;
    hcr_rx_t     rx;
    logic [7:0]  sel;
    logic [2:0]  op;
    logic        host_mode;
    logic        run;
    logic        arst;
    logic        alarm;
    logic [19:0] pre;
    logic [23:0] cnt;
    logic [15:0] disp1;
    logic [15:0] disp2;
  } hcr_dev_t;

  typedef struct packed {
    hcr_tx_t     tx;
    hcr_rx_t     rx;
    logic        busy;
    logic        wr;
    logic [15:0] tmo;
    logic        rsp_valid;
    logic        rsp_ok;
    logic [15:0] rsp_data;
  } hcr_host_t;

  function automatic logic [15:0] hcr_cs_init(input logic ascii);
    return ascii ? 16'h0000 : `HCR_CRC_INIT;
  endfunction

  // crc residue over data plus crc is zero; lrc sum likewise
  function automatic logic [15:0] hcr_cs_step(input logic ascii,
      input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `HCR_CRC_POLY) : (r >> 1);
    end
    return ascii ? {8'h00, 8'(c[7:0] + b)} : r;
  endfunction

  function automatic logic [7:0] hcr_hex_char(input logic [3:0] v);
    return (v < 4'hA) ? 8'(`HCR_CH_0 + v) : 8'(`HCR_CH_ALPHA + v);
  endfunction

  function automatic logic [4:0] hcr_hex_val(input logic [7:0] ch);
    if (ch >= `HCR_CH_0 && ch <= `HCR_CH_9)
      return {1'b1, ch[3:0]};
    if (ch >= `HCR_CH_UA && ch <= `HCR_CH_UF)
      return {1'b1, 4'(ch[3:0] + 4'h9)};
    return 5'h00;
  endfunction

  function automatic hcr_tx_t hcr_tx_start(input logic ascii,
      input logic [7:0][7:0] b, input logic [3:0] len);
    hcr_tx_t n;
    n = '0;
    n.busy = 1'b1;
    n.ph = ascii ? TX_HEAD : TX_BODY;
    n.len = len;
    n.cs = hcr_cs_init(ascii);
    n.bytes_ = b;
    return n;
  endfunction

  function automatic hcr_tx_t hcr_tx_step(input hcr_tx_t s,
      input logic ascii);
    hcr_tx_t n;
    logic [7:0] b;
    logic [7:0] lrc;
    n = s;
    n.valid = 1'b0;
    n.last = 1'b0;
    b = s.bytes_[s.idx[2:0]];
    lrc = 8'(~s.cs[7:0] + 8'h01);
    if (s.busy) begin
      n.valid = 1'b1;
      case (s.ph)
        TX_HEAD: begin
          n.data = `HCR_CH_COLON;
          n.ph = TX_BODY;
        end
        TX_BODY: begin
          n.data = ascii ? hcr_hex_char(s.nib ? b[3:0] : b[7:4]) : b;
          n.nib = ascii & ~s.nib;
          if (!ascii || s.nib) begin
            n.cs = hcr_cs_step(ascii, s.cs, b);
            n.idx = s.idx + 4'h1;
            if (n.idx == s.len)
              n.ph = TX_CS0;
          end
        end
        TX_CS0: begin
          n.data = ascii ? hcr_hex_char(lrc[7:4]) : s.cs[7:0];
          n.ph = TX_CS1;
        end
        TX_CS1: begin
          n.data = ascii ? hcr_hex_char(lrc[3:0]) : s.cs[15:8];
          n.ph = TX_CR;
          n.last = ~ascii;
          n.busy = ascii;
        end
        TX_CR: begin
          n.data = `HCR_CH_CR;
          n.ph = TX_LF;
        end
        TX_LF: begin
          n.data = `HCR_CH_LF;
          n.last = 1'b1;
          n.busy = 1'b0;
        end
        default: begin
          n.valid = 1'b0;
          n.busy = 1'b0;
        end
      endcase
    end
    return n;
  endfunction

  function automatic hcr_rx_t hcr_rx_step(input hcr_rx_t s,
      input logic ascii, input logic v, input logic [7:0] d,
      input logic last);
    hcr_rx_t n;
    logic [4:0] h;
    logic store;
    logic [7:0] b;
    n = s;
    n.done = 1'b0;
    h = hcr_hex_val(d);
    store = 1'b0;
    b = d;
    if (v && ascii) begin
      if (d == `HCR_CH_COLON) begin
        n.open = 1'b1;
        n.cnt = 4'h0;
        n.nib = 1'b0;
        n.cs = hcr_cs_init(1'b1);
      end else if (d == `HCR_CH_LF) begin
        n.done = s.open;
        n.open = 1'b0;
      end else if (h[4] && s.open) begin
        store = s.nib;
        b = {s.hi, h[3:0]};
        n.hi = h[3:0];
        n.nib = ~s.nib;
      end else if (d != `HCR_CH_CR) begin
        n.open = 1'b0;
      end
    end else if (v) begin
      if (!s.open) begin
        n.cnt = 4'h0;
        n.cs = hcr_cs_init(1'b0);
      end
      store = 1'b1;
      n.open = ~last;
      n.done = last;
    end
    if (store) begin
      if (!n.cnt[3])
        n.bytes_[n.cnt[2:0]] = b;
      if (n.cnt != 4'hF)
        n.cnt = n.cnt + 4'h1;
      n.cs = hcr_cs_step(ascii, n.cs, b);
    end
    n.ok = ascii ? (n.cs[7:0] == 8'h00) : (n.cs == 16'h0000);
    return n;
  endfunction

  function automatic logic [15:0] hcr_pick(input logic [3:0] sel,
      input logic [15:0] t, input logic [15:0] c, input logic [15:0] p);
    case (sel)
      `HCR_SEL_TEMP:  return t;
      `HCR_SEL_COND:  return c;
      `HCR_SEL_PRESS: return p;
      default:        return 16'h0000;
    endcase
  endfunction

endpackage

/* hw/hcr_link_if.sv */
`timescale 1ns/1ps
interface hcr_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_last;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_last;

  modport dev (
    input  h2d_data, h2d_valid, h2d_last,
    output d2h_data, d2h_valid, d2h_last
  );
  modport host (
    output h2d_data, h2d_valid, h2d_last,
    input  d2h_data, d2h_valid, d2h_last
  );
endinterface // hcr_link_if

/* hw/hcr_device.sv */
// Notes on behaviour
// - command bit 0 runs or stops unit in host mode
// - mode bit rising enters host mode, sticks until local_mode_req
// - reset bit rising gives one alarm reset in host mode
// - low nibble feeds display one, high two
// - codes none, temperature, conductivity, pressure
// - function 16 writes selector at 0043h
// - write answer echoes address, function, register, value
// - function 4 reads display one at 0038h
// - read answer: address, function, count, value, checksum
// - ascii hex pairs with lrc, rtu crc
// - watchdog counts only in host mode
// - silence for monitor time raises alarm
// - alarm alone does not stop operation
// - valid message clears alarm automatically
// - optional stop on alarm; restart needs start
// - host sends messages within watchdog time
// - temperature signed, tenth degree per count
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module hcr_device
  import hcr_pkg::*;
#(
  parameter int TICK_CYCLES   = `HCR_CLK_HZ / `HCR_TICKS_PER_S,
  parameter int MONITOR_TICKS = `HCR_MONITOR_S * `HCR_TICKS_PER_S
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // link
  hcr_link_if.dev          link,
  // configuration
  input  wire logic [7:0]  slave_addr,
  input  wire logic        ascii_mode,
  input  wire logic        wd_enable,
  input  wire logic        stop_on_alarm,
  input  wire logic        local_mode_req,
  // measurements
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] cond_value,
  input  wire logic [15:0] press_value,
  // unit status
  output logic             run_active,
  output logic             host_mode,
  output logic             alarm_reset,
  output logic             link_loss_alarm,
  output logic [15:0]      display_value_one,
  output logic [15:0]      display_value_two
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << 20)) begin : g_bad_tick
    $error("hcr_device: TICK_CYCLES out of range");
  end
  if (MONITOR_TICKS < 1 || MONITOR_TICKS >= (1 << 24)) begin : g_bad_mon
    $error("hcr_device: MONITOR_TICKS out of range");
  end

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
  localparam logic [23:0] MON_LAST  = 24'(MONITOR_TICKS - 1);

  hcr_dev_t s;
  hcr_dev_t next_s;

  // ----------------------------------------------------------------
  // frame decode helpers
  // ----------------------------------------------------------------
  logic [7:0][7:0] rb;
  logic [7:0][7:0] ans;
  logic [3:0]      plen;
  logic [15:0]     reg_a;
  logic [15:0]     val;
  logic [15:0]     rd;
  logic [2:0]      new_op;
  logic            hit;
  logic            req_ok;
  logic            rd_ok;
  logic            eff_mode;

  always_comb begin
    rb = s.rx.bytes_;
    plen = s.rx.cnt - (ascii_mode ? `HCR_LRC_LEN : `HCR_CRC_LEN);
    reg_a = {rb[2], rb[3]};
    val = {rb[4], rb[5]};
    hit = s.rx.done && s.rx.ok && rb[0] == slave_addr;
    req_ok = hit && plen == `HCR_REQ_LEN && !s.tx.busy;
    new_op = val[2:0];
    eff_mode = s.host_mode | (new_op[`HCR_OP_MODE] & ~s.op[`HCR_OP_MODE]);
    rd_ok = 1'b1;
    case (reg_a)
      `HCR_REG_DISP1:  rd = s.disp1;
      `HCR_REG_DISP2:  rd = s.disp2;
      `HCR_REG_SELECT: rd = {8'h00, s.sel};
      `HCR_REG_RUNCMD: rd = {13'h0000, s.op};
      default: begin
        rd = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
    ans = '0;
    ans[0] = rb[0];
    ans[1] = rb[1];
    ans[2] = `HCR_BYTE_COUNT;
    ans[3] = rd[15:8];
    ans[4] = rd[7:0];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.arst = 1'b0;
    next_s.tx = hcr_tx_step(s.tx, ascii_mode);
    next_s.rx = hcr_rx_step(s.rx, ascii_mode, link.h2d_valid,
                            link.h2d_data, link.h2d_last);
    next_s.disp1 = hcr_pick(s.sel[3:0], temp_value, cond_value,
                            press_value);
    next_s.disp2 = hcr_pick(s.sel[7:4], temp_value, cond_value,
                            press_value);

    if (req_ok && rb[1] == `HCR_FC_WRITE) begin
      if (reg_a == `HCR_REG_SELECT) begin
        next_s.sel = val[7:0];
        next_s.tx = hcr_tx_start(ascii_mode, rb, `HCR_REQ_LEN);
      end else if (reg_a == `HCR_REG_RUNCMD) begin
        next_s.op = new_op;
        next_s.host_mode = eff_mode;
        if (eff_mode) begin
          next_s.run = new_op[`HCR_OP_RUN];
          next_s.arst = new_op[`HCR_OP_ARST] & ~s.op[`HCR_OP_ARST];
        end
        next_s.tx = hcr_tx_start(ascii_mode, rb, `HCR_REQ_LEN);
      end
    end else if (req_ok && rb[1] == `HCR_FC_READ && val == `HCR_QTY_ONE
                 && rd_ok) begin
      next_s.tx = hcr_tx_start(ascii_mode, ans, `HCR_RD_RSP_LEN);
    end

    // local panel takes the unit back out of host mode
    if (local_mode_req) begin
      next_s.host_mode = 1'b0;
    end

    // ----------------------------------------------------------------
    // link-loss watchdog
    // ----------------------------------------------------------------
    // idle outside host mode
    if (!s.host_mode || !wd_enable) begin
      next_s.pre = 20'h00000;
      next_s.cnt = 24'h000000;
      next_s.alarm = 1'b0;
    end else if (hit) begin
      next_s.pre = 20'h00000;
      next_s.cnt = 24'h000000;
      next_s.alarm = 1'b0;
    end else if (s.pre == TICK_LAST) begin
      next_s.pre = 20'h00000;
      if (s.cnt == MON_LAST) begin
        next_s.alarm = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 24'h000001;
      end
    end else begin
      next_s.pre = s.pre + 20'h00001;
    end

    if (next_s.alarm && !s.alarm && stop_on_alarm) begin
      next_s.run = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.d2h_data    = s.tx.data;
  assign link.d2h_valid   = s.tx.valid & ce;
  assign link.d2h_last    = s.tx.last & ce;
  assign run_active       = s.run;
  assign host_mode        = s.host_mode;
  assign alarm_reset      = s.arst;
  assign link_loss_alarm  = s.alarm;
  assign display_value_one = s.disp1;
  assign display_value_two = s.disp2;

endmodule // hcr_device

/* hw/hcr_host.sv */
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module hcr_host
  import hcr_pkg::*;
#(
  parameter int RESP_TIMEOUT = `HCR_RSP_TIMEOUT
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // link
  hcr_link_if.host         link,
  // configuration
  input  wire logic [7:0]  slave_addr,
  input  wire logic        ascii_mode,
  // request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  // answer
  output logic             rsp_valid,
  output logic             rsp_ok,
  output logic [15:0]      rsp_data
);

  if (RESP_TIMEOUT < 2 || RESP_TIMEOUT >= (1 << 16)) begin : g_bad_tmo
    $error("hcr_host: RESP_TIMEOUT out of range");
  end
  localparam logic [15:0] TMO_LAST = 16'(RESP_TIMEOUT - 1);

  hcr_host_t s;
  hcr_host_t next_s;
  logic [7:0][7:0] qb;
  logic [7:0][7:0] rb;
  logic [3:0]      plen;
  logic            good;

  // ----------------------------------------------------------------
  // request build and answer check
  // ----------------------------------------------------------------
  always_comb begin
    qb = '0;
    qb[0] = slave_addr;
    qb[1] = req_write ? `HCR_FC_WRITE : `HCR_FC_READ;
    qb[2] = req_addr[15:8];
    qb[3] = req_addr[7:0];
    qb[4] = req_write ? req_data[15:8] : 8'(`HCR_QTY_ONE >> 8);
    qb[5] = req_write ? req_data[7:0] : 8'(`HCR_QTY_ONE);
    rb = s.rx.bytes_;
    plen = s.rx.cnt - (ascii_mode ? `HCR_LRC_LEN : `HCR_CRC_LEN);
    good = s.rx.ok && rb[0] == s.tx.bytes_[0]
           && rb[1] == s.tx.bytes_[1]
           && (s.wr ? (plen == `HCR_REQ_LEN
                       && rb[2] == s.tx.bytes_[2]
                       && rb[3] == s.tx.bytes_[3])
                    : (plen == `HCR_RD_RSP_LEN
                       && rb[2] == `HCR_BYTE_COUNT));
  end

  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    next_s.tx = hcr_tx_step(s.tx, ascii_mode);
    next_s.rx = hcr_rx_step(s.rx, ascii_mode, link.d2h_valid,
                            link.d2h_data, link.d2h_last);
    if (!s.busy) begin
      if (req_valid) begin
        next_s.busy = 1'b1;
        next_s.wr = req_write;
        next_s.tmo = 16'h0000;
        next_s.tx = hcr_tx_start(ascii_mode, qb, `HCR_REQ_LEN);
      end
    end else if (s.rx.done && !s.tx.busy) begin
      next_s.busy = 1'b0;
      next_s.rsp_valid = 1'b1;
      next_s.rsp_ok = good;
      next_s.rsp_data = s.wr ? {rb[4], rb[5]} : {rb[3], rb[4]};
    end else if (s.tmo == TMO_LAST) begin
      // silent device: give up so the next periodic poll can go
      next_s.busy = 1'b0;
      next_s.rsp_valid = 1'b1;
      next_s.rsp_ok = 1'b0;
      next_s.rsp_data = 16'h0000;
    end else begin
      next_s.tmo = s.tmo + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign link.h2d_data  = s.tx.data;
  assign link.h2d_valid = s.tx.valid & ce;
  assign link.h2d_last  = s.tx.last & ce;
  assign req_ready      = ~s.busy & ce;
  assign rsp_valid      = s.rsp_valid & ce;
  assign rsp_ok         = s.rsp_ok;
  assign rsp_data       = s.rsp_data;

endmodule // hcr_host

/* dv/hcr_link_checker.sv */
`timescale 1ns/1ps
module hcr_link_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // link
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_last,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_last
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // --------
  // answer kind, taken from its first char
  // --------
  logic asc;
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      asc <= 1'b0;
    else if ($rose(d2h_valid))
      asc <= (d2h_data == 8'h3A);
  end
  chk_last_valid: assert property (d2h_last |-> d2h_valid)
    else $error("answer end flag without a byte");
  chk_answer_delay: assert property ($rose(d2h_valid) |->
    $past(h2d_valid, 3) && !$past(h2d_valid, 2) && !$past(h2d_valid))
    else $error("answer not three cycles after request end");
  chk_no_overlap: assert property (!(h2d_valid && d2h_valid))
    else $error("request and answer overlap");
  chk_answer_len: assert property ($rose(d2h_valid) |->
    d2h_valid[*7])
    else $error("answer shorter than seven bytes");
  chk_answer_end: assert property ($fell(d2h_valid) |->
    $past(d2h_last))
    else $error("answer stopped without end flag");
  chk_ascii_tail: assert property (d2h_last && asc |->
    d2h_data == 8'h0A)
    else $error("text answer not ended by line feed");
  chk_read_count: assert property ($rose(d2h_valid) &&
    d2h_data != 8'h3A ##1 d2h_data == 8'h04 |=> d2h_data == 8'h02)
    else $error("read answer byte count wrong");
  chk_func_echo: assert property ($rose(d2h_valid) &&
    d2h_data != 8'h3A |=> d2h_data inside {8'h04, 8'h10})
    else $error("answer function code wrong");
  cover property (h2d_valid && h2d_data == 8'h3A);
  cover property (d2h_last && !asc);
  cover property (h2d_last);
endmodule // hcr_link_checker

/* dv/tb_host_command_register_slave.sv */
`timescale 1ns/1ps
module tb_host_command_register_slave;
  logic        ref_clk, reset_n, wd_en, stop_al, local_req, ascii, ce;
  logic        req_valid, req_write, req_ready, rsp_valid, rsp_ok;
  logic        run, hmode, arst, alarm;
  logic [7:0]  addr_h;
  logic [15:0] t_v, c_v, p_v, req_addr, req_data, rsp_data, d1, d2;
  int          err_count, n_compared, cyc, arst_seen;
  int          m_sel, m_cmd, m_host, m_run, n_arst;
  int          cw[7] = '{1, 3, 1, 5, 4, 'hFFFC, 'hFFF9};
  hcr_link_if lnk ();
  hcr_device #(.TICK_CYCLES(4), .MONITOR_TICKS(25)) u_hcr_device (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .link(lnk),
    .slave_addr(8'h01), .ascii_mode(ascii), .wd_enable(wd_en),
    .stop_on_alarm(stop_al), .local_mode_req(local_req),
    .temp_value(t_v), .cond_value(c_v), .press_value(p_v),
    .run_active(run), .host_mode(hmode), .alarm_reset(arst),
    .link_loss_alarm(alarm), .display_value_one(d1),
    .display_value_two(d2));
  hcr_host #(.RESP_TIMEOUT(200)) u_hcr_host (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .link(lnk),
    .slave_addr(addr_h), .ascii_mode(ascii), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data));
  hcr_link_checker u_hcr_link_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .h2d_data(lnk.h2d_data),
    .h2d_valid(lnk.h2d_valid), .h2d_last(lnk.h2d_last),
    .d2h_data(lnk.d2h_data), .d2h_valid(lnk.d2h_valid),
    .d2h_last(lnk.d2h_last));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (arst === 1'b1)
      arst_seen++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  // --------
  // compare and model
  // --------
  task automatic chk_val(string nm, int e, logic [15:0] g);
    n_compared++;
    if (g !== 16'(e)) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, 16'(e), g);
    end
  endtask
  task automatic chk_bit(string nm, int e, logic g);
    n_compared++;
    if (g !== 1'(e)) begin
      err_count++;
      $display("wrong value %s exp %b got %b", nm, 1'(e), g);
    end
  endtask
  function automatic int pick(int s);
    case (s & 15)
      1: return t_v;
      2: return c_v;
      3: return p_v;
      default: return 0;
    endcase
  endfunction
  function automatic int mread(int a);
    if (a == 'h38)
      return pick(m_sel);
    if (a == 'h39)
      return pick(m_sel >> 4);
    return (a == 'h43) ? m_sel : m_cmd;
  endfunction
  task automatic xfer(logic w, int a, int d, logic ok, int e);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = 16'(a);
    req_data = 16'(d);
    chk_bit("req_ready", 1, req_ready);
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (n = 0; n < 400 && rsp_valid !== 1'b1; n++)
      @(negedge ref_clk);
    chk_bit("rsp_valid", 1, rsp_valid);
    chk_bit("rsp_ok", ok, rsp_ok);
    if (ok)
      chk_val("rsp_data", e, rsp_data);
  endtask
  task automatic wr(int a, int d);
    if (a == 'h43)
      m_sel = d & 'hFF;
    else begin
      if ((d & 2) && !(m_cmd & 2))
        m_host = 1;
      if (m_host)
        m_run = d & 1;
      if (m_host && (d & 4) && !(m_cmd & 4))
        n_arst++;
      m_cmd = d & 7;
    end
    xfer(1'b1, a, d, 1'b1, d);
  endtask
  task automatic rd(int a);
    xfer(1'b0, a, 0, 1'b1, mread(a));
  endtask
  task automatic chk_state();
    chk_bit("run", m_run, run);
    chk_bit("host_mode", m_host, hmode);
    chk_val("disp1", pick(m_sel), d1);
    chk_val("disp2", pick(m_sel >> 4), d2);
    chk_val("alarm_reset", n_arst, 16'(arst_seen));
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // --------
  // tests
  // --------
  initial begin
    {reset_n, wd_en, stop_al, local_req, req_valid, req_write} = '0;
    {t_v, c_v, p_v, req_addr, req_data} = '0;
    ascii = 1'b1;
    ce = 1'b1;
    addr_h = 8'h01;
    void'($urandom(66));
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk_state();
    for (int m = 0; m < 2; m++) begin
      ascii = ~ascii;
      for (int i = 0; i < 6; i++) begin
        t_v = 16'($urandom);
        c_v = 16'($urandom);
        p_v = 16'($urandom);
        wr('h43, (i < 4) ? i * 17 : $urandom & 'hFF);
        rd('h38);
        rd('h39);
        rd('h43);
        chk_state();
      end
    end
    $display("test selection done");
    foreach (cw[i]) begin
      wr('h45, cw[i]);
      rd('h45);
      chk_state();
    end
    $display("test command done");
    wd_en = 1'b1;
    // frozen clock enable must not let the watchdog age
    ce = 1'b0;
    repeat (30) @(negedge ref_clk);
    chk_bit("req_ready", 0, req_ready);
    ce = 1'b1;
    repeat (80) @(negedge ref_clk);
    chk_bit("alarm", 0, alarm);
    repeat (40) @(negedge ref_clk);
    chk_bit("alarm", 1, alarm);
    chk_state();
    rd('h43);
    chk_bit("alarm", 0, alarm);
    stop_al = 1'b1;
    repeat (120) @(negedge ref_clk);
    m_run = 0;
    chk_state();
    wr('h45, 1);
    chk_state();
    addr_h = 8'h02;
    xfer(1'b0, 'h43, 0, 1'b0, 0);
    addr_h = 8'h01;
    xfer(1'b0, 'h50, 0, 1'b0, 0);
    m_run = 0;
    chk_bit("alarm", 1, alarm);
    chk_state();
    local_req = 1'b1;
    @(negedge ref_clk);
    local_req = 1'b0;
    m_host = 0;
    repeat (150) @(negedge ref_clk);
    chk_bit("alarm", 0, alarm);
    chk_state();
    $display("test watchdog done");
    close_out();
  end
endmodule // tb_host_command_register_slave
